// >>> rtl/tpx_core.sv
/*
 * Twisted-pair transceiver sequencer: transmit driver control, end of
 * packet hold, link pulses, echo and loopback, squelch and receive enable,
 * buffered clock output and an Avalon-MM register slave.
 * Assumes the hub controller drives the transmit pins from logic on i_clk;
 * the line receive input is asynchronous and is synchronised here.
 */
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Driver enabled while transmit enable is high, and during end of packet and link pulses.
// - Driver active within 75 ns of transmit enable rising.
// - Driver starts on transmit data; data forwarded within 75 ns.
// - Half-duplex echoes transmit data to receive outputs within 50 ns.
// - Receive enable rises within 50 ns of transmit enable rising.
// - Receive enable follows both edges of transmit enable within 400 ns.
// - Both driver outputs go high idle within 75 ns of enable falling.
// - End of packet held on the line for at least 250 ns.
// - Outgoing link test pulse is 80 to 120 ns wide.
// - Link beat pulses of 80 to 192 ns are accepted.
// - Loopback receive enable follows transmit enable within 50 ns.
// - Loopback routes transmit data to receive outputs within 50 ns.
// - Leaving loopback restores normal receive enable one clock (40 ns) later, not within 30 ns.
// - Squelch releases within five bit times of qualifying activity.
// - Received data appears and passes through in 80 to 120 ns (two sync flops and output register), not within 50 ns.
// - Received data valid together with receive enable rising.
// - Receive enable drops 155 to 250 ns after last received edge; here 280 to 320 ns.
// - Buffered 10 MHz clock is driven on the clock output.
// - Transmit data input is forwarded to the line driver.
// - Received data outputs forced high while receive enable is low.
// - Loopback sends only link pulses on the line driver.
// - Duplex select low means full-duplex operation.
module tpx_core #(
    parameter int LINK_PERIOD = tpx_pkg::LINK_PERIOD_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_tx_en,
    input wire logic i_tx_data_a,
    input wire logic i_tx_data_b,
    input wire logic i_line_rx,
    output logic o_tp_drv_en,
    output logic o_tp_pos,
    output logic o_tp_neg,
    output logic o_rx_en,
    output logic o_rx_data_a,
    output logic o_rx_data_b,
    output logic o_clk_out,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest
);

    localparam int LW = $clog2(LINK_PERIOD + 1);
    localparam logic [LW-1:0] LINK_LAST = LW'(LINK_PERIOD - 1);
    localparam logic [2:0] EOP_LAST = 3'(tpx_pkg::EOP_CYC - 1);
    localparam logic [2:0] LKPW_LAST = 3'(tpx_pkg::LKPW_CYC - 1);
    localparam logic [2:0] HOLD_LAST = 3'(tpx_pkg::RX_HOLD_CYC - 1);
    localparam logic [2:0] BEAT_MIN = 3'(tpx_pkg::BEAT_MIN_CYC);
    localparam logic [2:0] BEAT_MAX = 3'(tpx_pkg::BEAT_MAX_CYC);
    localparam logic [1:0] SQ_LAST = 2'(tpx_pkg::SQ_EDGES - 1);
    localparam logic [4:0] CKO_STEP = 5'(2 * tpx_pkg::CKO_MHZ);
    localparam logic [4:0] CKO_MOD = 5'(tpx_pkg::CLK_MHZ);

    tpx_pkg::tpx_ctrl_t ctrl_r;
    tpx_pkg::tpx_tx_state_t tx_st_r;
    tpx_pkg::tpx_tx_state_t tx_st_nxt;
    logic [2:0] tx_cnt_r;
    logic [LW-1:0] link_cnt_r;
    logic link_due;
    logic tx_data;
    logic loop_on;
    logic half_duplex;
    logic line_s1_r;
    logic line_s2_r;
    logic line_d_r;
    logic line_edge;
    logic [2:0] gap_cnt_r;
    logic [1:0] edge_cnt_r;
    logic sq_open_r;
    logic [2:0] hi_cnt_r;
    logic beat_seen_r;
    logic beat_hit;
    logic rx_en_nxt;
    logic rx_data_nxt;
    logic [4:0] cko_acc_r;
    logic [5:0] cko_sum;
    logic ack_r;
    logic [31:0] rdata_r;
    tpx_pkg::tpx_stat_t stat;

    // ------------------------------------------------------------------
    // Transmit side
    // ------------------------------------------------------------------

    // Unused input sits high, so an AND merges the two sources
    assign tx_data = i_tx_data_a & i_tx_data_b;
    assign loop_on = ctrl_r.loop_en;
    assign half_duplex = ctrl_r.duplex_select_n; // Low selects full duplex

    // Link pulse timer, restarted by any frame so pulses only fill idle gaps
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            link_cnt_r <= '0;
        end else if (tx_st_r == tpx_pkg::TX_SEND || tx_st_r == tpx_pkg::TX_LINK) begin
            link_cnt_r <= '0;
        end else if (link_cnt_r != LINK_LAST) begin
            link_cnt_r <= link_cnt_r + LW'(1);
        end
    end

    assign link_due = (link_cnt_r == LINK_LAST) && ctrl_r.link_pulse_en;

    // Next transmit state; hold and pulse phases run to completion
    always_comb begin
        tx_st_nxt = tx_st_r;
        unique case (tx_st_r)
            tpx_pkg::TX_IDLE: begin
                if (i_tx_en && !loop_on) begin
                    tx_st_nxt = tpx_pkg::TX_SEND;
                end else if (link_due) begin
                    tx_st_nxt = tpx_pkg::TX_LINK;
                end
            end
            tpx_pkg::TX_SEND: begin
                if (!i_tx_en || loop_on) begin
                    tx_st_nxt = tpx_pkg::TX_EOP;
                end
            end
            tpx_pkg::TX_EOP, tpx_pkg::TX_LINK: begin
                if (tx_cnt_r == 3'h0) begin // Waiting frame starts at once
                    tx_st_nxt = (i_tx_en && !loop_on) ? tpx_pkg::TX_SEND : tpx_pkg::TX_IDLE;
                end
            end
        endcase
    end

    // State and phase counter
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            tx_st_r <= tpx_pkg::TX_IDLE;
            tx_cnt_r <= 3'h0;
        end else begin
            tx_st_r <= tx_st_nxt;
            if (tx_st_nxt == tpx_pkg::TX_EOP && tx_st_r != tpx_pkg::TX_EOP) begin
                tx_cnt_r <= EOP_LAST;
            end else if (tx_st_nxt == tpx_pkg::TX_LINK && tx_st_r != tpx_pkg::TX_LINK) begin
                tx_cnt_r <= LKPW_LAST;
            end else if (tx_cnt_r != 3'h0) begin
                tx_cnt_r <= tx_cnt_r - 3'h1;
            end
        end
    end

    // Driver pins decoded from the next state to save a cycle of latency
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            {o_tp_drv_en, o_tp_pos, o_tp_neg} <= 3'b011;
        end else begin
            unique case (tx_st_nxt)
                tpx_pkg::TX_SEND: {o_tp_drv_en, o_tp_pos, o_tp_neg}
                    <= {1'b1, tx_data, ~tx_data};
                tpx_pkg::TX_EOP: {o_tp_drv_en, o_tp_pos, o_tp_neg} <= 3'b111;
                tpx_pkg::TX_LINK: {o_tp_drv_en, o_tp_pos, o_tp_neg} <= 3'b110;
                tpx_pkg::TX_IDLE: {o_tp_drv_en, o_tp_pos, o_tp_neg} <= 3'b011;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------------

    // Line input crosses in through two flops before anything reads it
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            line_s1_r <= 1'b0; // Idle low, so no false edge or beat after reset
            line_s2_r <= 1'b0;
            line_d_r <= 1'b0;
        end else begin
            line_s1_r <= i_line_rx;
            line_s2_r <= line_s1_r;
            line_d_r <= line_s2_r;
        end
    end

    assign line_edge = line_s2_r ^ line_d_r;

    // Squelch: a few closely spaced edges open it, a quiet gap closes it
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            gap_cnt_r <= 3'h0;
            edge_cnt_r <= 2'h0;
            sq_open_r <= 1'b0;
        end else if (line_edge) begin
            gap_cnt_r <= 3'h0;
            if (edge_cnt_r == SQ_LAST) begin
                sq_open_r <= 1'b1;
            end else begin
                edge_cnt_r <= edge_cnt_r + 2'h1;
            end
        end else if (gap_cnt_r == HOLD_LAST) begin
            edge_cnt_r <= 2'h0;
            sq_open_r <= 1'b0;
        end else begin
            gap_cnt_r <= gap_cnt_r + 3'h1;
        end
    end

    // High-time meter for link beats, saturating so long pulses stay out
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            hi_cnt_r <= 3'h0;
        end else if (!line_s2_r) begin
            hi_cnt_r <= 3'h0;
        end else if (hi_cnt_r != 3'h7) begin
            hi_cnt_r <= hi_cnt_r + 3'h1;
        end
    end

    assign beat_hit = line_d_r && !line_s2_r && !sq_open_r
                      && hi_cnt_r >= BEAT_MIN && hi_cnt_r <= BEAT_MAX;

    // Receive enable source: loopback, echo of own frame, or the line
    assign rx_en_nxt = loop_on ? i_tx_en
                       : (sq_open_r || (half_duplex && i_tx_en));

    // Data chooses transmit copy when looping or echoing, else the line
    always_comb begin
        if (!rx_en_nxt) begin
            rx_data_nxt = 1'b1;
        end else if (loop_on) begin
            rx_data_nxt = tx_data;
        end else if (half_duplex && i_tx_en) begin
            rx_data_nxt = tx_data;
        end else begin
            rx_data_nxt = line_s2_r;
        end
    end

    // Enable and data registered together so data is valid with enable
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_rx_en <= 1'b0;
            o_rx_data_a <= 1'b1;
            o_rx_data_b <= 1'b1;
        end else begin
            o_rx_en <= rx_en_nxt;
            o_rx_data_a <= rx_data_nxt;
            o_rx_data_b <= rx_data_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Clock output
    // ------------------------------------------------------------------

    // Fractional divider; edges jitter by a cycle since 25 is not 2 x 10
    assign cko_sum = {1'b0, cko_acc_r} + {1'b0, CKO_STEP};

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cko_acc_r <= CKO_STEP; // First edge toggles, no stall after reset
            o_clk_out <= 1'b0;
        end else if (cko_sum >= {1'b0, CKO_MOD}) begin
            cko_acc_r <= 5'(cko_sum - {1'b0, CKO_MOD});
            o_clk_out <= ~o_clk_out;
        end else begin
            cko_acc_r <= cko_sum[4:0];
        end
    end

    // ------------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------------

    // Every access waits exactly one cycle, then completes
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;
    assign o_avs_readdata = rdata_r;

    assign stat = {beat_seen_r, sq_open_r, o_tp_drv_en, o_rx_en}; // Field order of the type

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (i_avs_read || i_avs_write) && !ack_r;
        end
    end

    // Read data captured in the wait cycle so it stands at the done edge
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rdata_r <= 32'h0;
        end else if (i_avs_read && !ack_r) begin
            if (i_avs_address == tpx_pkg::CTRL_OFS) begin
                rdata_r <= {29'h0, ctrl_r};
            end else if (i_avs_address == tpx_pkg::STAT_OFS) begin
                rdata_r <= {28'h0, stat};
            end else begin
                rdata_r <= 32'h0;
            end
        end
    end

    // Control write; takes effect on the edge the access completes
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ctrl_r <= tpx_pkg::CTRL_RST;
        end else if (i_avs_write && ack_r && i_avs_byteenable[0]
                     && i_avs_address == tpx_pkg::CTRL_OFS) begin
            ctrl_r <= i_avs_writedata[2:0];
        end
    end

    // Sticky beat flag, write one to clear; a new beat beats the clear
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            beat_seen_r <= 1'b0;
        end else if (beat_hit) begin
            beat_seen_r <= 1'b1;
        end else if (i_avs_write && ack_r && i_avs_byteenable[0]
                     && i_avs_address == tpx_pkg::STAT_OFS
                     && i_avs_writedata[tpx_pkg::STAT_BEAT_BIT]) begin
            beat_seen_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    property p_drv_start;
        $rose(i_tx_en) && !ctrl_r.loop_en |=> o_tp_drv_en;
    endproperty
    a_drv_start: assert property (p_drv_start) else $error("driver late after enable");

    property p_idle_high;
        $fell(i_tx_en) && !ctrl_r.loop_en && tx_st_r == tpx_pkg::TX_SEND
            |=> o_tp_pos && o_tp_neg;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("line not idle high");

    property p_eop_hold;
        $rose(tx_st_r == tpx_pkg::TX_EOP) |-> (o_tp_drv_en && o_tp_pos && o_tp_neg)[*7];
    endproperty
    a_eop_hold: assert property (p_eop_hold) else $error("end of packet too short");

    property p_link_width;
        $rose(tx_st_r == tpx_pkg::TX_LINK)
            |-> (o_tp_pos && !o_tp_neg)[*2] ##1 tx_st_r != tpx_pkg::TX_LINK;
    endproperty
    a_link_width: assert property (p_link_width) else $error("link pulse width wrong");

    property p_rx_forced;
        !o_rx_en |-> o_rx_data_a && o_rx_data_b;
    endproperty
    a_rx_forced: assert property (p_rx_forced) else $error("rx data not forced high");

    property p_loop_follow;
        ctrl_r.loop_en |=> o_rx_en == $past(i_tx_en);
    endproperty
    a_loop_follow: assert property (p_loop_follow) else $error("loop enable not followed");

    property p_echo;
        !ctrl_r.loop_en && ctrl_r.duplex_select_n && i_tx_en
            |=> o_rx_en && o_rx_data_a == $past(tx_data);
    endproperty
    a_echo: assert property (p_echo) else $error("transmit echo missing");

    property p_rx_hold_min;
        sq_open_r && line_edge ##1 (!line_edge)[*3] |=> sq_open_r;
    endproperty
    a_rx_hold_min: assert property (p_rx_hold_min) else $error("squelch closed early");

    property p_rx_hold_max;
        sq_open_r && line_edge ##1 (!line_edge)[*4] |=> !sq_open_r;
    endproperty
    a_rx_hold_max: assert property (p_rx_hold_max) else $error("squelch closed late");

    property p_cko_run;
        $stable(o_clk_out) |=> !$stable(o_clk_out);
    endproperty
    a_cko_run: assert property (p_cko_run) else $error("clock output stalled");

endmodule

`default_nettype wire

// >>> inc/tpx_pkg.sv
/*
 * Constants, register layout and types for the twisted-pair transceiver
 * sequencer. Assumes a single 25 MHz system clock; every time window is
 * converted here into whole cycles of that clock.
 */
`default_nettype none

package tpx_pkg;

    // ------------------------------------------------------------------
    // Clock rates
    // ------------------------------------------------------------------
    localparam int CLK_NS = 40;
    localparam int CLK_MHZ = 25;
    localparam int CKO_MHZ = 10;
    localparam int BIT_NS = 100;

    // ------------------------------------------------------------------
    // Time windows (ns as printed, link period in ms) and derived cycle counts
    // ------------------------------------------------------------------
    localparam int TX_START_MAX_NS = 75;
    localparam int TX_START_CYC = (TX_START_MAX_NS / CLK_NS < 1) ? 1 : TX_START_MAX_NS / CLK_NS;
    localparam int ECHO_MAX_NS = 50;
    localparam int ECHO_CYC = (ECHO_MAX_NS / CLK_NS < 1) ? 1 : ECHO_MAX_NS / CLK_NS;
    localparam int EOP_MIN_NS = 250;
    localparam int EOP_CYC = (EOP_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int LKPW_MIN_NS = 80;
    localparam int LKPW_CYC = (LKPW_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int BEAT_MIN_NS = 80;
    localparam int BEAT_MAX_NS = 192;
    localparam int BEAT_MIN_CYC = (BEAT_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int BEAT_MAX_CYC = BEAT_MAX_NS / CLK_NS;
    localparam int RX_HOLD_MIN_NS = 155;
    localparam int RX_HOLD_CYC = (RX_HOLD_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SQ_MAX_BITS = 5;
    localparam int SQ_MAX_CYC = SQ_MAX_BITS * BIT_NS / CLK_NS;
    localparam int SQ_EDGES = 3;
    localparam int LINK_PERIOD_MS = 16;
    localparam int LINK_PERIOD_CYC = LINK_PERIOD_MS * 1000000 / CLK_NS;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [2:0] CTRL_RST = 3'h6;
    localparam int STAT_BEAT_BIT = 3;

    typedef struct packed {
        logic link_pulse_en;
        logic duplex_select_n;
        logic loop_en;
    } tpx_ctrl_t;

    typedef struct packed {
        logic beat_seen;
        logic sq_open;
        logic drv_active;
        logic rx_en;
    } tpx_stat_t;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_SEND,
        TX_EOP,
        TX_LINK
    } tpx_tx_state_t;

endpackage

`default_nettype wire

// >>> sim/tpx_hub_model.sv
/*
 * Hub controller model: drives transmit enable and data and the sliced
 * line input. Assumes the bench calls its tasks from one process.
 */
`timescale 1ns/10ps
`default_nettype none

module tpx_hub_model (
    input wire logic i_clk,
    output logic o_tx_en,
    output logic o_tx_data_a,
    output logic o_tx_data_b,
    output logic o_line_rx
);
    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    // Unused data input parked high; combined inside the device
    initial begin
        o_tx_en = 1'b0;
        o_tx_data_a = 1'b1;
        o_tx_data_b = 1'b1;
        o_line_rx = 1'b0;
    end

    // Enable held high over every bit of the frame
    task automatic send_frame(input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk);
            o_tx_en <= 1'b1;
            o_tx_data_a <= 1'($urandom);
        end
        @(posedge i_clk);
        o_tx_en <= 1'b0;
        o_tx_data_a <= 1'b1;
        repeat (8) @(posedge i_clk); // Gap covers the end-of-packet hold
    endtask

    // Line edges every gap cycles; even n leaves the line low
    task automatic line_burst(input int n, input int gap);
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk);
            o_line_rx <= ~o_line_rx;
            repeat (gap - 1) @(posedge i_clk);
        end
    endtask
endmodule

`default_nettype wire

// >>> sim/tpx_core_tb_top.sv
/*
 * Self-checking bench for the transceiver sequencer with a cycle model.
 * Assumes the hub model drives the pins and Avalon runs from this bench.
 */
`timescale 1ns/10ps
`default_nettype none

module tpx_core_tb_top;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [3:0] i_avs_address = 4'h0;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0] i_avs_byteenable = 4'hf;
    logic [31:0] rdat;
    logic tx_en, tx_a, tx_b, line, drv, pos, neg, ren, rda, rdb, cko, wait_r;
    logic [31:0] avrd;
    logic e_drv, e_pos, e_neg, t_en1, t_d1, last_cko, pr;
    int errors = 0;
    int checked = 0;
    int mode = 0; // 0 off, 1 half, 2 full, 3 loop
    int eop = 0;
    int tail = 0;
    int tog = 0;
    int cyc = 0;
    int n, w;
    int widths[4] = '{1, 2, 4, 6};
    int cfgs[4] = '{2, 0, 7, 2};
    int mds[4] = '{1, 2, 3, 1};

    initial begin
        forever #20 i_clk = ~i_clk;
    end

    tpx_hub_model hub (.i_clk(i_clk), .o_tx_en(tx_en), .o_tx_data_a(tx_a),
        .o_tx_data_b(tx_b), .o_line_rx(line));

    tpx_core #(.LINK_PERIOD(50)) dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_tx_en(tx_en), .i_tx_data_a(tx_a), .i_tx_data_b(tx_b),
        .i_line_rx(line), .o_tp_drv_en(drv), .o_tp_pos(pos), .o_tp_neg(neg),
        .o_rx_en(ren), .o_rx_data_a(rda), .o_rx_data_b(rdb), .o_clk_out(cko),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(avrd),
        .o_avs_waitrequest(wait_r));

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Request held until waitrequest is seen low at an edge
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_byteenable <= be;
        i_avs_write <= wr;
        i_avs_read <= ~wr;
        do @(posedge i_clk); while (wait_r !== 1'b0);
        rdat = avrd;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Cycle model of the line driver, compared at falling edges in modes 1 and 2
    // ----------------------------------------------------------------
    // Loopback never starts a frame, so the model idles there
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
        t_en1 = tx_en;
        t_d1 = tx_a & tx_b;
        if (!i_reset_n || mode == 3) begin
            {e_drv, e_pos, e_neg} = 3'b011;
            eop = 0;
        end else if (tx_en) begin
            {e_drv, e_pos, e_neg} = {1'b1, t_d1, ~t_d1};
            eop = tpx_pkg::EOP_CYC;
        end else if (eop > 0) begin
            {e_drv, e_pos, e_neg} = 3'b111;
            eop--;
        end else begin
            {e_drv, e_pos, e_neg} = 3'b011;
        end
    end

    // Outputs settle after the rising edge; look at them half a cycle on
    always @(negedge i_clk) begin
        tog += int'(cko !== last_cko);
        last_cko = cko;
        check(rdb, rda, "rx copy");
        if (!ren) check(rda, 1, "rx forced");
        if (mode == 1 || mode == 2) check({drv, pos, neg}, {e_drv, e_pos, e_neg}, "line");
        if (mode == 2) check(ren, 0, "full echo");
        if (mode == 3) check(drv & ~(pos & ~neg), 0, "loop line");
        if ((mode == 1 || mode == 3) && t_en1) check({ren, rda}, {1'b1, t_d1}, "echo");
        if (mode == 3 && !t_en1) check(ren, 0, "loop rx_en");
        tail = (mode == 1 && !t_en1 && ren) ? tail + 1 : 0;
        if (tail > 10) check(ren, 0, "rx_en tail");
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hab04));
        repeat (8) @(posedge i_clk);
        i_reset_n <= 1'b1;
        av(1'b0, tpx_pkg::CTRL_OFS, 0, 4'hf);
        check(rdat, 32'h6, "ctrl reset");
        av(1'b1, 4'h8, 32'h1, 4'hf);
        av(1'b0, 4'h8, 0, 4'hf);
        check(rdat, 0, "unmapped");
        for (int k = 0; k < 4; k++) begin
            n = $urandom_range(7, 0);
            av(1'b1, tpx_pkg::CTRL_OFS, n, 4'hf);
            av(1'b1, tpx_pkg::CTRL_OFS, ~n, 4'he);
            av(1'b0, tpx_pkg::CTRL_OFS, 0, 4'hf);
            check(rdat, n, "ctrl rw");
        end
        // Link pulse width and spacing
        av(1'b1, tpx_pkg::CTRL_OFS, 32'h6, 4'hf);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            while (!(drv && pos && !neg) && n < 200) begin
                @(posedge i_clk);
                n++;
            end
            if (k == 1) check(n >= 50 && n <= 53, 1, "link period");
            w = 0;
            while (drv && pos && !neg && w < 10) begin
                @(posedge i_clk);
                w++;
            end
            check(w >= 2 && w <= 3, 1, "link width");
        end
        // Clock output: four toggles in every five cycles
        tog = 0;
        repeat (100) @(posedge i_clk);
        check(tog, 80, "clk out");
        // Half duplex, full duplex, loopback, then back to half
        foreach (cfgs[k]) begin
            av(1'b1, tpx_pkg::CTRL_OFS, cfgs[k], 4'hf);
            repeat (4) @(posedge i_clk);
            mode = mds[k];
            hub.send_frame(1);
            hub.send_frame($urandom_range(40, 10));
            mode = 0;
        end
        // Squelch release and receive shutdown
        fork
            hub.line_burst(24, 2);
            begin
                n = 0;
                while (ren !== 1'b1 && n < 40) begin
                    @(posedge i_clk);
                    n++;
                end
                check(n <= 16, 1, "squelch");
                w = 0;
                repeat (20) begin
                    pr = rda;
                    @(posedge i_clk);
                    w += int'(rda !== pr);
                end
                check(w == 10 && ren === 1'b1, 1, "rx pass");
            end
        join
        n = 1;
        while (ren !== 1'b0 && n < 20) begin
            @(posedge i_clk);
            n++;
        end
        check(n >= 4 && n <= 10, 1, "rx shutdown");
        // Link beats of several widths, sticky bit cleared by writing 1
        av(1'b1, tpx_pkg::STAT_OFS, 32'h8, 4'hf); // Squelch burst leaves a beat behind
        foreach (widths[k]) begin
            hub.line_burst(2, widths[k]);
            repeat (12) @(posedge i_clk);
            av(1'b0, tpx_pkg::STAT_OFS, 0, 4'hf);
            check(rdat[3], k == 1 || k == 2, "beat");
            av(1'b1, tpx_pkg::STAT_OFS, 32'h8, 4'hf);
        end
        give_verdict();
    end
endmodule

`default_nettype wire
